// >>> logic/ecct_pkg.sv
// package of the 8-bit capture/compare timer: register map, fields, resets
// assumes a 32-bit ahb-lite bus, one register per aligned word
package ecct_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL_B = 8'h3c;
	localparam logic [7:0] IDX_CTRL_A = 8'h3d;
	localparam logic [7:0] IDX_FLAGS = 8'h3e;
	localparam logic [7:0] IDX_CAP_ONE = 8'h3f;
	localparam logic [7:0] IDX_CMP_ONE = 8'h40;
	localparam logic [7:0] IDX_CNT_MAIN = 8'h41;
	localparam logic [7:0] IDX_CNT_ALT = 8'h42;
	localparam logic [7:0] IDX_CAP_TWO = 8'h43;
	localparam logic [7:0] IDX_CMP_TWO = 8'h44;
	// timer_control_a fields
	localparam int CA_CAP_IRQ = 7;
	localparam int CA_CMP_IRQ = 6;
	localparam int CA_OVF_IRQ = 5;
	localparam int CA_FORCE_TWO = 4;
	localparam int CA_FORCE_ONE = 3;
	localparam int CA_LEVEL_TWO = 2;
	localparam int CA_EDGE_ONE = 1;
	localparam int CA_LEVEL_ONE = 0;
	// timer_control_b fields
	localparam int CB_PIN_ONE = 7;
	localparam int CB_PIN_TWO = 6;
	localparam int CB_PULSE = 5;
	localparam int CB_PWM = 4;
	localparam int CB_CLK_HI = 3;
	localparam int CB_CLK_LO = 2;
	localparam int CB_EDGE_TWO = 1;
	localparam logic [7:0] CB_WRITE_MASK = 8'hfe;
	// timer_flags fields
	localparam int FL_CAP_ONE = 7;
	localparam int FL_MATCH_ONE = 6;
	localparam int FL_OVF = 5;
	localparam int FL_CAP_TWO = 4;
	localparam int FL_MATCH_TWO = 3;
	localparam int FL_FREEZE = 2;
	// reset values and counter maximum
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic [7:0] CNT_RESET = 8'hfc;
	localparam logic [7:0] CNT_MAX = 8'hff;
	// clock select codes and prescaler masks
	localparam logic [1:0] CLK_DIV4 = 2'b00;
	localparam logic [1:0] CLK_DIV2 = 2'b01;
	localparam logic [1:0] CLK_DIV8 = 2'b10;
	localparam logic [1:0] CLK_OSC = 2'b11;
	localparam logic [2:0] MASK_DIV2 = 3'h1;
	localparam logic [2:0] MASK_DIV4 = 3'h3;
	localparam logic [2:0] MASK_DIV8 = 3'h7;
	localparam int OSC_DIV_DEFAULT = 8000;
	// ahb-lite codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic HRESP_OKAY = 1'b0;
	// bus slave states
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_WAIT = 3'b010,
		BUS_DONE = 3'b100
	} ecct_bus_t;
endpackage

// >>> logic/ecct_timer.sv
// 8-bit capture/compare timer with ahb-lite register slave
// assumes one clock clk, pins asynchronous, osc_clk_in a slow level input
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
module ecct_timer #(
	parameter int OSC_DIV = ecct_pkg::OSC_DIV_DEFAULT // osc ticks per count
) (
	input wire logic clk, // cpu clock, 10 mhz
	input wire logic rst, // async reset, active high
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size, word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic [31:0] hrdata, // read data
	output logic hresp, // always okay
	input wire logic osc_clk_in, // slow oscillator level
	input wire logic irq_mask, // processor global mask, high masks
	input wire logic capture_input_one, // capture pin one
	input wire logic capture_input_two, // capture pin two
	output logic compare_output_one, // compare pin one level
	output logic compare_output_one_oe, // pin one owned by timer
	output logic compare_output_two, // compare pin two level
	output logic compare_output_two_oe, // pin two owned by timer
	output logic timer_irq // shared timer interrupt
);
	import ecct_pkg::*;

	// refuse divisors the osc counter cannot hold
	if (OSC_DIV < 1 || OSC_DIV > 65536) begin : g_chk
		$error("OSC_DIV out of range");
	end

	ecct_bus_t bus_reg;
	logic [7:0] idx_reg;
	logic wr_reg;
	logic [7:0] rdata_reg;
	logic [7:0] ctrl_a_reg;
	logic [7:0] ctrl_b_reg;
	logic freeze_reg;
	logic [7:0] flags_reg;
	logic [7:0] arm_reg;
	logic [7:0] cap_one_reg;
	logic [7:0] cap_two_reg;
	logic [7:0] cmp_one_reg;
	logic [7:0] cmp_two_reg;
	logic [7:0] act_one_reg;
	logic [7:0] act_two_reg;
	logic [7:0] cnt_reg;
	logic moved_reg;
	logic [2:0] div_reg;
	logic [15:0] osc_cnt_reg;
	logic [2:0] osc_sync_reg;
	logic osc_filt_reg;
	logic [2:0] in1_sync_reg;
	logic [2:0] in2_sync_reg;
	logic in1_filt_reg;
	logic in2_filt_reg;
	logic out_one_reg;
	logic out_two_reg;
	logic accept;
	logic act;
	logic act_wr;
	logic act_rd;
	logic [7:0] wdata;
	logic pwm_on;
	logic pulse_on;
	logic tick;
	logic osc_rise;
	logic in1_next;
	logic in2_next;
	logic edge_one;
	logic edge_two;
	logic match_one;
	logic match_two;
	logic ovf_evt;
	logic sw_cnt_reset;
	logic [7:0] set_flags;
	logic [7:0] clr_flags;
	logic [7:0] read_mux;

	// register index decode, shared by strobe and read paths
	function automatic logic is_idx(input logic [7:0] a, input logic [7:0] i);
		return a == i;
	endfunction

	assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign act = (bus_reg == BUS_WAIT);
	assign act_wr = act && wr_reg;
	assign act_rd = act && !wr_reg;
	assign wdata = hwdata[7:0];
	assign hreadyout = (bus_reg != BUS_WAIT);
	assign hrdata = {24'h000000, rdata_reg};
	assign hresp = HRESP_OKAY;

	// bus phases: address taken, one wait cycle acts, then answer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_reg <= BUS_IDLE;
			idx_reg <= 8'h00;
			wr_reg <= 1'b0;
		end else begin
			case (bus_reg)
			BUS_WAIT: bus_reg <= BUS_DONE;
			default: begin
				if (accept) begin
					bus_reg <= BUS_WAIT;
					idx_reg <= (haddr[31:10] == 22'h000000) ? haddr[9:2] : 8'hff;
					wr_reg <= hwrite;
				end else begin
					bus_reg <= BUS_IDLE;
				end
			end
			endcase
		end
	end

	// read data selection; unmapped reads as zero
	always_comb begin
		if (is_idx(idx_reg, IDX_CTRL_B)) begin
			read_mux = ctrl_b_reg;
		end else if (is_idx(idx_reg, IDX_CTRL_A)) begin
			read_mux = ctrl_a_reg;
		end else if (is_idx(idx_reg, IDX_FLAGS)) begin
			read_mux = flags_reg;
		end else if (is_idx(idx_reg, IDX_CAP_ONE)) begin
			read_mux = cap_one_reg;
		end else if (is_idx(idx_reg, IDX_CMP_ONE)) begin
			read_mux = cmp_one_reg;
		end else if (is_idx(idx_reg, IDX_CNT_MAIN)) begin
			read_mux = cnt_reg;
		end else if (is_idx(idx_reg, IDX_CNT_ALT)) begin
			read_mux = cnt_reg;
		end else if (is_idx(idx_reg, IDX_CAP_TWO)) begin
			read_mux = cap_two_reg;
		end else if (is_idx(idx_reg, IDX_CMP_TWO)) begin
			read_mux = cmp_two_reg;
		end else begin
			read_mux = 8'h00;
		end
	end

	// read data held until the next read completes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (act_rd) begin
			rdata_reg <= read_mux;
		end
	end

	// control registers; reserved bit of control b stays zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_a_reg <= CTRL_RESET;
			ctrl_b_reg <= CTRL_RESET;
			freeze_reg <= 1'b0;
			cmp_one_reg <= CMP_RESET;
			cmp_two_reg <= CMP_RESET;
		end else if (act_wr) begin
			if (is_idx(idx_reg, IDX_CTRL_A)) begin
				ctrl_a_reg <= wdata;
			end else if (is_idx(idx_reg, IDX_CTRL_B)) begin
				ctrl_b_reg <= wdata & CB_WRITE_MASK;
			end else if (is_idx(idx_reg, IDX_FLAGS)) begin
				freeze_reg <= wdata[FL_FREEZE];
			end else if (is_idx(idx_reg, IDX_CMP_ONE)) begin
				cmp_one_reg <= wdata;
			end else if (is_idx(idx_reg, IDX_CMP_TWO)) begin
				cmp_two_reg <= wdata;
			end
		end
	end

	// pwm wins over pulse mode when both are set
	assign pwm_on = ctrl_b_reg[CB_PWM];
	assign pulse_on = ctrl_b_reg[CB_PULSE] && !pwm_on;

	// working compare values; in pwm they change only at period end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			act_one_reg <= CMP_RESET;
			act_two_reg <= CMP_RESET;
		end else if (!pwm_on || match_two) begin
			act_one_reg <= cmp_one_reg;
			act_two_reg <= cmp_two_reg;
		end
	end

	// input synchronisers; filtered level follows when stages 2 and 3 agree
	assign in1_next = (in1_sync_reg[1] == in1_sync_reg[2]) ?
		in1_sync_reg[2] : in1_filt_reg;
	assign in2_next = (in2_sync_reg[1] == in2_sync_reg[2]) ?
		in2_sync_reg[2] : in2_filt_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in1_sync_reg <= 3'h0;
			in2_sync_reg <= 3'h0;
			osc_sync_reg <= 3'h0;
			in1_filt_reg <= 1'b0;
			in2_filt_reg <= 1'b0;
			osc_filt_reg <= 1'b0;
		end else begin
			in1_sync_reg <= {in1_sync_reg[1:0], capture_input_one};
			in2_sync_reg <= {in2_sync_reg[1:0], capture_input_two};
			osc_sync_reg <= {osc_sync_reg[1:0], osc_clk_in};
			in1_filt_reg <= in1_next;
			in2_filt_reg <= in2_next;
			if (osc_sync_reg[1] == osc_sync_reg[2]) begin
				osc_filt_reg <= osc_sync_reg[2];
			end
		end
	end

	// active edges chosen by the edge select bits
	assign edge_one = (in1_next != in1_filt_reg) &&
		(in1_next == ctrl_a_reg[CA_EDGE_ONE]);
	assign edge_two = (in2_next != in2_filt_reg) &&
		(in2_next == ctrl_b_reg[CB_EDGE_TWO]);
	assign osc_rise = (osc_sync_reg[1] == osc_sync_reg[2]) &&
		osc_sync_reg[2] && !osc_filt_reg;

	// prescaler: cpu divider and osc divider, both frozen by freeze bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= 3'h0;
			osc_cnt_reg <= 16'h0000;
		end else if (!freeze_reg) begin
			div_reg <= div_reg + 3'h1;
			if (osc_rise) begin
				if (osc_cnt_reg == 16'(OSC_DIV - 1)) begin
					osc_cnt_reg <= 16'h0000;
				end else begin
					osc_cnt_reg <= osc_cnt_reg + 16'h0001;
				end
			end
		end
	end

	// timer tick from the selected clock
	always_comb begin
		case (ctrl_b_reg[CB_CLK_HI:CB_CLK_LO])
		CLK_DIV4: tick = (div_reg & MASK_DIV4) == MASK_DIV4;
		CLK_DIV2: tick = (div_reg & MASK_DIV2) == MASK_DIV2;
		CLK_DIV8: tick = (div_reg & MASK_DIV8) == MASK_DIV8;
		default: tick = osc_rise && (osc_cnt_reg == 16'(OSC_DIV - 1));
		endcase
		if (freeze_reg) begin
			tick = 1'b0;
		end
	end

	// software write to either counter register resets the count
	assign sw_cnt_reset = act_wr && (is_idx(idx_reg, IDX_CNT_MAIN) ||
		is_idx(idx_reg, IDX_CNT_ALT));
	assign ovf_evt = tick && (cnt_reg == CNT_MAX) && !sw_cnt_reset;

	// counter with reload priority: software, pwm period, pulse trigger
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= CNT_RESET;
			moved_reg <= 1'b0;
		end else begin
			moved_reg <= 1'b0;
			if (sw_cnt_reset) begin
				cnt_reg <= CNT_RESET;
			end else if (pwm_on && match_two) begin
				cnt_reg <= CNT_RESET;
			end else if (pulse_on && edge_one) begin
				cnt_reg <= CNT_RESET;
			end else if (tick) begin
				cnt_reg <= cnt_reg + 8'h01;
				moved_reg <= 1'b1;
			end
		end
	end

	// matches are judged once each time the counter advances
	assign match_one = moved_reg && (cnt_reg == act_one_reg);
	assign match_two = moved_reg && (cnt_reg == act_two_reg);

	// capture value registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cap_one_reg <= 8'h00;
			cap_two_reg <= 8'h00;
		end else begin
			if (edge_one && !pwm_on && !pulse_on) begin
				cap_one_reg <= cnt_reg;
			end
			if (edge_two) begin
				cap_two_reg <= cnt_reg;
			end
		end
	end

	// flag events; pwm blocks match flags, pulse blocks match one
	always_comb begin
		set_flags = 8'h00;
		set_flags[FL_CAP_ONE] = (edge_one && !pwm_on) ||
			(pwm_on && match_two);
		set_flags[FL_MATCH_ONE] = match_one && !pwm_on && !pulse_on;
		set_flags[FL_OVF] = ovf_evt;
		set_flags[FL_CAP_TWO] = edge_two;
		set_flags[FL_MATCH_TWO] = match_two && !pwm_on;
	end

	// second step of clearing: access to the paired register after arming
	always_comb begin
		clr_flags = 8'h00;
		if (act) begin
			clr_flags[FL_CAP_ONE] = arm_reg[FL_CAP_ONE] &&
				is_idx(idx_reg, IDX_CAP_ONE);
			clr_flags[FL_MATCH_ONE] = arm_reg[FL_MATCH_ONE] &&
				is_idx(idx_reg, IDX_CMP_ONE);
			clr_flags[FL_OVF] = arm_reg[FL_OVF] &&
				is_idx(idx_reg, IDX_CNT_MAIN);
			clr_flags[FL_CAP_TWO] = arm_reg[FL_CAP_TWO] &&
				is_idx(idx_reg, IDX_CAP_TWO);
			clr_flags[FL_MATCH_TWO] = arm_reg[FL_MATCH_TWO] &&
				is_idx(idx_reg, IDX_CMP_TWO);
		end
	end

	// sticky flags, set wins over clear; status read arms the clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_reg <= 8'h00;
			arm_reg <= 8'h00;
		end else begin
			for (int i = FL_MATCH_TWO; i <= FL_CAP_ONE; i++) begin
				if (set_flags[i]) begin
					flags_reg[i] <= 1'b1;
				end else if (clr_flags[i]) begin
					flags_reg[i] <= 1'b0;
				end
				if (act_rd && is_idx(idx_reg, IDX_FLAGS)) begin
					arm_reg[i] <= flags_reg[i];
				end else if (clr_flags[i]) begin
					arm_reg[i] <= 1'b0;
				end
			end
			flags_reg[FL_FREEZE] <= freeze_reg;
		end
	end

	// compare output levels: force, match and mode steering
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_one_reg <= 1'b0;
			out_two_reg <= 1'b0;
		end else begin
			if (ctrl_a_reg[CA_FORCE_ONE]) begin
				out_one_reg <= ctrl_a_reg[CA_LEVEL_ONE];
			end else if ((pwm_on && match_two) ||
				(pulse_on && edge_one)) begin
				out_one_reg <= ctrl_a_reg[CA_LEVEL_TWO];
			end else if (match_one) begin
				out_one_reg <= ctrl_a_reg[CA_LEVEL_ONE];
			end
			if (ctrl_a_reg[CA_FORCE_TWO]) begin
				out_two_reg <= ctrl_a_reg[CA_LEVEL_TWO];
			end else if (match_two && !pwm_on && !pulse_on) begin
				out_two_reg <= ctrl_a_reg[CA_LEVEL_TWO];
			end
		end
	end

	// pins belong to the timer only while enabled and not frozen
	assign compare_output_one = out_one_reg;
	assign compare_output_two = out_two_reg;
	assign compare_output_one_oe = ctrl_b_reg[CB_PIN_ONE] && !freeze_reg;
	assign compare_output_two_oe = ctrl_b_reg[CB_PIN_TWO] && !freeze_reg;

	// one shared interrupt from enabled flags, blocked by global mask
	assign timer_irq = !irq_mask && (
		(ctrl_a_reg[CA_CAP_IRQ] &&
			(flags_reg[FL_CAP_ONE] || flags_reg[FL_CAP_TWO])) ||
		(ctrl_a_reg[CA_CMP_IRQ] &&
			(flags_reg[FL_MATCH_ONE] || flags_reg[FL_MATCH_TWO])) ||
		(ctrl_a_reg[CA_OVF_IRQ] && flags_reg[FL_OVF]));

	// hsize is fixed at word; nothing else to check
	logic unused_ok;
	assign unused_ok = &{1'b0, hsize, hwdata[31:8], haddr[1:0]};
endmodule // ecct_timer

// >>> verification/ecct_timer_asserts.sv
// checker of bus timing, irq gating, forced levels and pin ownership
// assumes hready is tied to hreadyout and a single clock domain
`timescale 1ns/1ns
module ecct_timer_asserts
	import ecct_pkg::*;
#(
	parameter int OSC_DIV = OSC_DIV_DEFAULT // osc ticks per count
) (
	input wire logic clk, // cpu clock
	input wire logic rst, // async reset
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write flag
	input wire logic [2:0] hsize, // size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	input wire logic hreadyout, // slave ready
	input wire logic [31:0] hrdata, // read data
	input wire logic hresp, // response
	input wire logic osc_clk_in, // slow clock
	input wire logic irq_mask, // global mask
	input wire logic capture_input_one, // capture pin one
	input wire logic capture_input_two, // capture pin two
	input wire logic compare_output_one, // pin one level
	input wire logic compare_output_one_oe, // pin one owned
	input wire logic compare_output_two, // pin two level
	input wire logic compare_output_two_oe, // pin two owned
	input wire logic timer_irq // timer interrupt
);
	logic ph_wr;
	logic [7:0] ph_idx;
	logic [7:0] sh_a;
	logic [7:0] sh_b;
	logic sh_fz;
	logic [16:0] cfg;
	// shadow control writes, committed at the end of the wait cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph_wr <= 1'b0;
			ph_idx <= 8'h00;
			sh_a <= 8'h00;
			sh_b <= 8'h00;
			sh_fz <= 1'b0;
		end else if (hsel && hready && htrans == HTRANS_NONSEQ) begin
			ph_wr <= hwrite && haddr[31:10] == 22'h0;
			ph_idx <= haddr[9:2];
		end else if (ph_wr && !hreadyout) begin
			ph_wr <= 1'b0;
			if (ph_idx == IDX_CTRL_A) sh_a <= hwdata[7:0];
			if (ph_idx == IDX_CTRL_B) sh_b <= hwdata[7:0];
			if (ph_idx == IDX_FLAGS) sh_fz <= hwdata[FL_FREEZE];
		end
	end
	assign cfg = {sh_a, sh_b, sh_fz};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_take;
		hsel && hready && htrans == HTRANS_NONSEQ;
	endsequence
	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	wait_state_a: assert property (s_take |=> s_wait)
		else $error("wait state not exactly one cycle");
	rdata_hold_a: assert property (!$stable(hrdata) |-> $past(hreadyout) == 1'b0)
		else $error("read data changed outside a read");
	upper_zero_a: assert property (hrdata[31:8] == 24'h0 && hresp == HRESP_OKAY)
		else $error("read data upper bits or response wrong");
	irq_masked_a: assert property (irq_mask |-> !timer_irq)
		else $error("irq raised while masked");
	irq_quiet_a: assert property (
		sh_a[7:5] == 3'b000 && $stable(cfg) |-> !timer_irq)
		else $error("irq raised with all enables clear");
	force_one_a: assert property (
		sh_a[CA_FORCE_ONE] && sh_b[CB_PIN_ONE] && !sh_fz && $stable(cfg)
		|-> compare_output_one == sh_a[CA_LEVEL_ONE])
		else $error("forced level one not on pin one");
	force_two_a: assert property (
		sh_a[CA_FORCE_TWO] && sh_b[CB_PIN_TWO] && !sh_fz && $stable(cfg)
		|-> compare_output_two == sh_a[CA_LEVEL_TWO])
		else $error("forced level two not on pin two");
	oe_one_a: assert property ($stable(cfg) |->
		compare_output_one_oe == (sh_b[CB_PIN_ONE] && !sh_fz))
		else $error("pin one ownership wrong");
	oe_two_a: assert property ($stable(cfg) |->
		compare_output_two_oe == (sh_b[CB_PIN_TWO] && !sh_fz))
		else $error("pin two ownership wrong");
endmodule // ecct_timer_asserts

bind ecct_timer ecct_timer_asserts #(.OSC_DIV(OSC_DIV)) u_chk (
	.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.osc_clk_in(osc_clk_in), .irq_mask(irq_mask),
	.capture_input_one(capture_input_one),
	.capture_input_two(capture_input_two),
	.compare_output_one(compare_output_one),
	.compare_output_one_oe(compare_output_one_oe),
	.compare_output_two(compare_output_two),
	.compare_output_two_oe(compare_output_two_oe), .timer_irq(timer_irq));

// >>> verification/tb.sv
// self-checking bench of the capture/compare timer over ahb-lite
// assumes one wait state per transfer and a small oscillator divider
`timescale 1ns/1ns
module tb;
	import ecct_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic mask = 1'b1;
	logic cap1 = 1'b1;
	logic cap2 = 1'b1;
	logic [1:0] osc_cnt = 2'b00;
	logic hready, hresp, o1, o1e, o2, o2e, irq, lv, hit;
	logic [31:0] hrdata;
	logic [7:0] v;
	int n_mismatch = 0;
	int num_checks = 0;
	int hi;
	int dv[4] = '{4, 2, 8, 16};
	logic [7:0] ri[4] = '{IDX_CTRL_A, IDX_CTRL_B, IDX_CMP_ONE, IDX_CMP_TWO};
	logic [7:0] rw[4] = '{8'ha5, 8'hc3, 8'h80, 8'h81};
	// clock and a slow oscillator of four cpu cycles
	always #50 clk = ~clk;
	always @(posedge clk) osc_cnt <= osc_cnt + 2'd1;
	ecct_timer #(.OSC_DIV(4)) dut (.clk(clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hrdata(hrdata), .hresp(hresp), .osc_clk_in(osc_cnt[1]),
		.irq_mask(mask), .capture_input_one(cap1),
		.capture_input_two(cap2), .compare_output_one(o1),
		.compare_output_one_oe(o1e), .compare_output_two(o2),
		.compare_output_two_oe(o2e), .timer_irq(irq));
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string w, input logic [7:0] s,
		input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", w, e, s);
		end
	endtask
	// one single ahb-lite transfer, waits on hready in both phases
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		// only the watchdog ends a wait that never sees hready
		do begin
			@(posedge clk);
		end while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		do begin
			@(posedge clk);
		end while (hready !== 1'b1);
		v = hrdata[7:0];
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		bus(1'b1, {22'h0, i, 2'b00}, d);
	endtask
	task automatic get(input logic [7:0] i);
		bus(1'b0, {22'h0, i, 2'b00}, 8'h00);
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e, string w);
		get(i);
		check(w, v, e);
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wr(IDX_FLAGS, 8'hff);
		rd(IDX_FLAGS, 8'h04, "flags");
		for (int k = 0; k < 4; k++) begin
			rd(ri[k], 8'h00, "reset value");
			wr(ri[k], rw[k]);
			rd(ri[k], rw[k] & (k == 1 ? CB_WRITE_MASK : 8'hff), "reg");
		end
		bus(1'b1, 32'h400, 8'h55);
		rd(8'h00, 8'h00, "unmapped");
		bus(1'b0, 32'h400, 8'h00);
		check("unmapped", v, 8'h00);
		wr(IDX_CNT_MAIN, 8'h33);
		rd(IDX_CNT_ALT, CNT_RESET, "count");
		// every clock select code, over a span of about eight ticks of that code
		for (int k = 0; k < 4; k++) begin
			wr(IDX_CTRL_B, {4'h0, k[1:0], 2'b00});
			wr(IDX_CNT_MAIN, 8'h00);
			wr(IDX_FLAGS, 8'h00);
			repeat (8 * dv[k]) @(posedge clk);
			wr(IDX_FLAGS, 8'h04);
			get(IDX_CNT_MAIN);
			v = v - CNT_RESET;
			check("ticks", {7'h0, v >= 8'd8 && v <= 8'd10},
				8'h01);
		end
		// overflow flag, irq gating and two-step clear
		rd(IDX_FLAGS, 8'h24, "flags");
		wr(IDX_CTRL_A, 8'h20);
		mask <= 1'b0;
		@(posedge clk);
		check("irq", {7'h0, irq}, 8'h01);
		get(IDX_CNT_ALT);
		rd(IDX_FLAGS, 8'h24, "flags");
		get(IDX_CNT_MAIN);
		rd(IDX_FLAGS, 8'h04, "flags");
		check("irq", {7'h0, irq}, 8'h00);
		// captures on both inputs, both edges, both selects
		wr(IDX_CNT_MAIN, 8'h00);
		for (int c = 0; c < 2; c++)
			for (int e = 0; e < 2; e++)
				for (int t = 0; t < 2; t++) begin
					wr(IDX_CTRL_A, c ? 8'h80 : {6'h20, e[0], 1'b0});
					wr(IDX_CTRL_B, c ? {6'h0, e[0], 1'b0} : 8'h00);
					lv = c ? ~cap2 : ~cap1;
					hit = (lv == e[0]);
					if (c) cap2 <= lv;
					else cap1 <= lv;
					repeat (8) @(posedge clk);
					get(IDX_FLAGS);
					check("flags", v, {c ? 3'b000 : {hit, 2'b00}, c ? hit : 1'b0,
						4'h4});
					check("irq", {7'h0, irq}, {7'h0, hit});
					get(c ? IDX_CAP_TWO : IDX_CAP_ONE);
					if (hit) check("capture", v, CNT_RESET);
					rd(IDX_FLAGS, 8'h04, "flags");
				end
		// matches with pins enabled, then with pins released
		wr(IDX_CMP_ONE, 8'h02);
		wr(IDX_CMP_TWO, 8'h05);
		for (int r = 0; r < 2; r++) begin
			wr(IDX_CTRL_A, r ? 8'h40 : 8'h45);
			wr(IDX_CTRL_B, r ? 8'h04 : 8'hc4);
			wr(IDX_CNT_MAIN, 8'h00);
			wr(IDX_FLAGS, 8'h00);
			repeat (40) @(posedge clk);
			check("oe", {6'h0, o1e, o2e}, r ? 8'h00 : 8'h03);
			// levels still follow matches while the pins are released
			check("pins", {6'h0, o1, o2},
				r ? 8'h00 : 8'h03);
			check("irq", {7'h0, irq}, 8'h01);
			wr(IDX_FLAGS, 8'h04);
			rd(IDX_FLAGS, 8'h6c, "flags");
			rd(IDX_CMP_ONE, 8'h02, "cmp one");
			rd(IDX_FLAGS, 8'h2c, "flags");
			rd(IDX_CMP_TWO, 8'h05, "cmp two");
			rd(IDX_FLAGS, 8'h24, "flags");
			get(IDX_CNT_MAIN);
		end
		// forced levels override matching
		wr(IDX_CTRL_B, 8'hc4);
		for (int f = 0; f < 2; f++) begin
			// pins start low, so forcing high first shows the override
			wr(IDX_CTRL_A, f ? 8'h18 : 8'h1d);
			wr(IDX_FLAGS, 8'h00);
			repeat (4) @(posedge clk);
			check("forced", {6'h0, o1, o2},
				f ? 8'h00 : 8'h03);
		end
		// pwm: high time and period, flags in pwm
		wr(IDX_FLAGS, 8'h04);
		wr(IDX_CTRL_A, 8'h04);
		get(IDX_FLAGS);
		wr(IDX_CMP_ONE, 8'h10);
		wr(IDX_CMP_TWO, 8'h20);
		wr(IDX_CNT_MAIN, 8'h00);
		wr(IDX_CTRL_B, 8'h94);
		wr(IDX_FLAGS, 8'h00);
		repeat (150) @(posedge clk);
		hi = 0;
		repeat (148) begin
			@(posedge clk);
			hi += o1;
		end
		check("pwm high", {7'h0, hi >= 80 && hi <= 88},
			8'h01);
		wr(IDX_FLAGS, 8'h04);
		get(IDX_FLAGS);
		check("pwm flags", v & 8'hc8, 8'h80);
		get(IDX_CNT_MAIN);
		check("pwm count", {7'h0, v <= 8'h21 || v >= 8'hfc},
			8'h01);
		// single pulse: rising capture one edge starts one pulse
		get(IDX_CAP_ONE);
		wr(IDX_CTRL_B, 8'ha4);
		wr(IDX_CTRL_A, 8'h0e);
		wr(IDX_CMP_ONE, 8'h08);
		wr(IDX_CTRL_A, 8'h06);
		wr(IDX_FLAGS, 8'h00);
		cap1 <= 1'b0;
		repeat (8) @(posedge clk);
		check("pulse idle", {7'h0, o1}, 8'h00);
		cap1 <= 1'b1;
		repeat (10) @(posedge clk);
		check("pulse on", {7'h0, o1}, 8'h01);
		repeat (30) @(posedge clk);
		check("pulse off", {7'h0, o1}, 8'h00);
		get(IDX_FLAGS);
		check("pulse flags", v & 8'hc0, 8'h80);
		summarize();
	end
endmodule // tb
